// *** hdl/rtc_raster_controller.v ***
// Summary of operation
// - Data bus drivers enabled only during a host read of the device.
// - Register data moves on the falling edge of the bus enable strobe.
// - Register select 0 reaches the index, 1 the indexed data register.
// - Read/write low writes the register file, high reads it.
// - Line sync, frame sync, display enable active high; enable only in active area.
// - Fourteen-bit refresh address covers a 16K block, high means one.
// - Five-bit row address comes straight from the raster counter.
// - Active-high cursor output marks where the cursor is shown.
// - Display outputs move on the falling edge of the character clock.
// - Pen strobe rising edge latches the refresh address at next character edge.
// - Chip reset clears all counters but the blink counter, stops display, outputs low, registers kept.
// - Chip reset acts only with pen strobe low; pen high selects test mode.
// - Address outputs go low with character clock low; reset lasts one cycle.
// - Display resumes at once after chip reset release, no reprogramming.
// - Interlace mode: bit0 clear normal, 01 sync, 11 sync and video.
// - Maximum scan line holds scan lines per row minus one.
// - Cursor start: low five bits first line, bit6 blink, bit5 rate.
// - Cursor end register holds the last cursor scan line.
// - Fourteen-bit start address is first refresh address after vertical blanking.
// - Pen capture register is fourteen-bit read-only, loaded on strobe.
// - Cursor position is a fourteen-bit read/write register.
// - Cursor asserts when cursor position equals refresh address.
// - Raster counter at maximum resets and advances the row counter.
// - Frame sync lasts sixteen raster lines, not programmable.
`timescale 1ns/10ps
`include "rtc_defines.vh"

module rtc_raster_controller #(
   parameter MA_W = 14,
   parameter RA_W = 5
) (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_ce,
   input wire i_char_clk,
   input wire i_chip_reset_n,
   input wire i_pen_strobe_pin,
   input wire i_bus_enable,
   input wire i_cs_n,
   input wire i_register_select,
   input wire i_read_write_n,
   input wire [7:0] i_host_data_bus,
   output reg [7:0] o_host_data_bus,
   output wire o_host_data_bus_oe,
   output wire o_line_sync_pulse,
   output wire o_frame_sync_pulse,
   output wire o_display_enable,
   output wire o_cursor,
   output wire [MA_W-1:0] o_refresh_address_out,
   output wire [RA_W-1:0] o_char_row_address_out,
   output wire o_test_mode
);

   // ----------------------------------------
   // Register decode helpers
   // ----------------------------------------
   function hit;
      input [4:0] idx;
      input [4:0] num;
      begin
         hit = (idx == num);
      end
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg char_q_reg;
   reg enable_q_reg;
   reg pen_q_reg;
   reg pen_pend_reg;
   reg [4:0] index_reg;
   reg [7:0] h_total_reg;
   reg [7:0] h_disp_reg;
   reg [7:0] h_sync_pos_reg;
   reg [3:0] h_sync_wid_reg;
   reg [6:0] v_total_reg;
   reg [4:0] v_adjust_reg;
   reg [6:0] v_disp_reg;
   reg [6:0] v_sync_pos_reg;
   reg [1:0] scan_interlace_mode_reg;
   reg [4:0] max_scan_line_reg;
   reg [6:0] cursor_first_line_format_reg;
   reg [4:0] cursor_last_line_reg;
   reg [13:0] display_start_reg;
   reg [13:0] cursor_position_reg;
   reg [13:0] pen_capture_reg;
   reg [7:0] h_cnt_reg;
   reg [4:0] raster_reg;
   reg [6:0] v_cnt_reg;
   reg adj_reg;
   reg [4:0] adj_cnt_reg;
   reg field_reg;
   reg [4:0] blink_cnt_reg;
   reg [13:0] ma_reg;
   reg [13:0] row_start_reg;
   reg hsync_reg;
   reg [3:0] hs_cnt_reg;
   reg vsync_reg;
   reg [3:0] vs_cnt_reg;
   reg de_reg;
   reg cursor_reg;
   reg [7:0] rd_next;

   wire char_fall;
   wire enable_fall;
   wire bus_sel;
   wire wr_strobe;
   wire reset_hold;
   wire line_end;
   wire vid_mode;
   wire raster_last;
   wire row_end;
   wire v_last;
   wire frame_end;
   wire [4:0] raster_first;
   wire [4:0] raster_step;
   wire vs_start;
   wire hs_last;
   wire blink_on;
   wire cur_line_hit;
   wire [4:0] cur_first;

   // ----------------------------------------
   // Edge detection on sampled pins
   // ----------------------------------------
   // Falling character edge
   assign char_fall = char_q_reg & ~i_char_clk;
   assign enable_fall = enable_q_reg & ~i_bus_enable;
   assign bus_sel = ~i_cs_n;
   assign wr_strobe = enable_fall & bus_sel & ~i_read_write_n;
   assign reset_hold = ~i_chip_reset_n & ~i_pen_strobe_pin;
   assign o_test_mode = ~i_chip_reset_n & i_pen_strobe_pin;

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         char_q_reg <= 1'b0;
         enable_q_reg <= 1'b0;
         pen_q_reg <= 1'b0;
      end else if (i_ce) begin
         char_q_reg <= i_char_clk;
         enable_q_reg <= i_bus_enable;
         pen_q_reg <= i_pen_strobe_pin;
      end
   end

   // ----------------------------------------
   // Register file writes
   // ----------------------------------------
   // Chip reset leaves this file alone; only the async reset clears it.
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         index_reg <= `RTC_RST_INDEX;
         h_total_reg <= `RTC_RST_BYTE;
         h_disp_reg <= `RTC_RST_BYTE;
         h_sync_pos_reg <= `RTC_RST_BYTE;
         h_sync_wid_reg <= 4'h0;
         v_total_reg <= 7'h00;
         v_adjust_reg <= 5'h00;
         v_disp_reg <= 7'h00;
         v_sync_pos_reg <= 7'h00;
         scan_interlace_mode_reg <= 2'h0;
         max_scan_line_reg <= 5'h00;
         cursor_first_line_format_reg <= 7'h00;
         cursor_last_line_reg <= 5'h00;
         display_start_reg <= `RTC_RST_ADDR;
         cursor_position_reg <= `RTC_RST_ADDR;
      end else if (i_ce && wr_strobe) begin
         if (!i_register_select) begin
            index_reg <= i_host_data_bus[4:0];
         end else begin
            if (hit(index_reg, `RTC_IDX_H_TOTAL)) h_total_reg <= i_host_data_bus;
            if (hit(index_reg, `RTC_IDX_H_DISP)) h_disp_reg <= i_host_data_bus;
            if (hit(index_reg, `RTC_IDX_H_SYNC_POS)) h_sync_pos_reg <= i_host_data_bus;
            if (hit(index_reg, `RTC_IDX_H_SYNC_WID)) h_sync_wid_reg <= i_host_data_bus[3:0];
            if (hit(index_reg, `RTC_IDX_V_TOTAL)) v_total_reg <= i_host_data_bus[6:0];
            if (hit(index_reg, `RTC_IDX_V_ADJUST)) v_adjust_reg <= i_host_data_bus[4:0];
            if (hit(index_reg, `RTC_IDX_V_DISP)) v_disp_reg <= i_host_data_bus[6:0];
            if (hit(index_reg, `RTC_IDX_V_SYNC_POS)) v_sync_pos_reg <= i_host_data_bus[6:0];
            if (hit(index_reg, `RTC_IDX_INTERLACE)) scan_interlace_mode_reg <= i_host_data_bus[1:0];
            if (hit(index_reg, `RTC_IDX_MAX_SCAN)) max_scan_line_reg <= i_host_data_bus[4:0];
            if (hit(index_reg, `RTC_IDX_CUR_FIRST)) cursor_first_line_format_reg <= i_host_data_bus[6:0];
            if (hit(index_reg, `RTC_IDX_CUR_LAST)) cursor_last_line_reg <= i_host_data_bus[4:0];
            if (hit(index_reg, `RTC_IDX_START_HI)) display_start_reg[13:8] <= i_host_data_bus[5:0];
            if (hit(index_reg, `RTC_IDX_START_LO)) display_start_reg[7:0] <= i_host_data_bus;
            if (hit(index_reg, `RTC_IDX_CUR_POS_HI)) cursor_position_reg[13:8] <= i_host_data_bus[5:0];
            if (hit(index_reg, `RTC_IDX_CUR_POS_LO)) cursor_position_reg[7:0] <= i_host_data_bus;
         end
      end
   end

   // ----------------------------------------
   // Register file reads
   // ----------------------------------------
   // Write-only registers and the index read as zero.
   always @* begin
      rd_next = 8'h00;
      if (i_register_select) begin
         if (hit(index_reg, `RTC_IDX_CUR_POS_HI)) rd_next = {2'h0, cursor_position_reg[13:8]};
         if (hit(index_reg, `RTC_IDX_CUR_POS_LO)) rd_next = cursor_position_reg[7:0];
         if (hit(index_reg, `RTC_IDX_PEN_HI)) rd_next = {2'h0, pen_capture_reg[13:8]};
         if (hit(index_reg, `RTC_IDX_PEN_LO)) rd_next = pen_capture_reg[7:0];
      end
   end

   // Read data is reloaded each cycle while enable is high and held once it falls, so it is stable at the falling edge.
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_host_data_bus <= 8'h00;
      end else if (i_ce) begin
         if (i_bus_enable && bus_sel && i_read_write_n) begin
            o_host_data_bus <= rd_next;
         end
      end
   end

   assign o_host_data_bus_oe = i_bus_enable & bus_sel & i_read_write_n;

   // ----------------------------------------
   // Timing decode
   // ----------------------------------------
   assign line_end = (h_cnt_reg == h_total_reg);
   assign vid_mode = scan_interlace_mode_reg[`RTC_MODE_INTERLACE_BIT] &
                     scan_interlace_mode_reg[`RTC_MODE_VIDEO_BIT];
   assign raster_step = vid_mode ? 5'h02 : 5'h01;
   assign raster_first = vid_mode ? {4'h0, field_reg} : 5'h00;
   assign raster_last = vid_mode ? (raster_reg[4:1] == max_scan_line_reg[4:1]) :
                        (raster_reg == max_scan_line_reg);
   assign row_end = line_end & raster_last & ~adj_reg;
   assign v_last = (v_cnt_reg == v_total_reg);
   assign frame_end = (row_end & v_last & (v_adjust_reg == 5'h00)) |
                      (adj_reg & line_end & (adj_cnt_reg == v_adjust_reg - 5'h01));
   assign vs_start = row_end & ~v_last & ((v_cnt_reg + 7'h01) == v_sync_pos_reg);
   // Zero width means sixteen characters
   assign hs_last = ((hs_cnt_reg + 4'h1) == h_sync_wid_reg);

   assign blink_on = ~cursor_first_line_format_reg[`RTC_CUR_BLINK_BIT] ?
                     ~cursor_first_line_format_reg[`RTC_CUR_RATE_BIT] :
                     (cursor_first_line_format_reg[`RTC_CUR_RATE_BIT] ? blink_cnt_reg[4] : blink_cnt_reg[3]);
   assign cur_first = cursor_first_line_format_reg[`RTC_CUR_LINE_MSB:0];
   assign cur_line_hit = (raster_reg >= cur_first) & (raster_reg <= cursor_last_line_reg);

   // ----------------------------------------
   // Raster counters and address generator
   // ----------------------------------------
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         h_cnt_reg <= 8'h00;
         raster_reg <= 5'h00;
         v_cnt_reg <= 7'h00;
         adj_reg <= 1'b0;
         adj_cnt_reg <= 5'h00;
         field_reg <= 1'b0;
         blink_cnt_reg <= 5'h00;
         ma_reg <= `RTC_RST_ADDR;
         row_start_reg <= `RTC_RST_ADDR;
         hsync_reg <= 1'b0;
         hs_cnt_reg <= 4'h0;
         vsync_reg <= 1'b0;
         vs_cnt_reg <= 4'h0;
         de_reg <= 1'b0;
         cursor_reg <= 1'b0;
      end else if (i_ce) begin
         if (reset_hold) begin
            if (!i_char_clk) begin
               h_cnt_reg <= 8'h00;
               raster_reg <= 5'h00;
               v_cnt_reg <= 7'h00;
               adj_reg <= 1'b0;
               adj_cnt_reg <= 5'h00;
               field_reg <= 1'b0;
               // Resume from zero
               // Address pins must read low here; start address reloads at frame end
               ma_reg <= `RTC_RST_ADDR;
               row_start_reg <= `RTC_RST_ADDR;
               hsync_reg <= 1'b0;
               hs_cnt_reg <= 4'h0;
               vsync_reg <= 1'b0;
               vs_cnt_reg <= 4'h0;
               de_reg <= 1'b0;
               cursor_reg <= 1'b0;
            end
         end else if (char_fall) begin
            de_reg <= (h_cnt_reg < h_disp_reg) & (v_cnt_reg < v_disp_reg) & ~adj_reg;
            cursor_reg <= (ma_reg == cursor_position_reg) & cur_line_hit & blink_on &
                          (h_cnt_reg < h_disp_reg) & (v_cnt_reg < v_disp_reg) & ~adj_reg;
            // Line sync pulse
            if (hsync_reg) begin
               hs_cnt_reg <= hs_cnt_reg + 4'h1;
               if (hs_last) begin
                  hsync_reg <= 1'b0;
               end
            end else if (h_cnt_reg == h_sync_pos_reg) begin
               hsync_reg <= 1'b1;
               hs_cnt_reg <= 4'h0;
            end
            if (frame_end) begin
               h_cnt_reg <= 8'h00;
               v_cnt_reg <= 7'h00;
               adj_reg <= 1'b0;
               adj_cnt_reg <= 5'h00;
               field_reg <= scan_interlace_mode_reg[`RTC_MODE_INTERLACE_BIT] ? ~field_reg : 1'b0;
               raster_reg <= (vid_mode ? {4'h0, ~field_reg} : 5'h00);
               blink_cnt_reg <= blink_cnt_reg + 5'h01;
               ma_reg <= display_start_reg;
               row_start_reg <= display_start_reg;
            end else if (line_end) begin
               h_cnt_reg <= 8'h00;
               if (row_end) begin
                  raster_reg <= raster_first;
                  if (v_last) begin
                     adj_reg <= 1'b1;
                     adj_cnt_reg <= 5'h00;
                  end else begin
                     v_cnt_reg <= v_cnt_reg + 7'h01;
                  end
                  row_start_reg <= row_start_reg + {6'h00, h_disp_reg};
                  ma_reg <= row_start_reg + {6'h00, h_disp_reg};
               end else begin
                  raster_reg <= raster_reg + raster_step;
                  if (adj_reg) begin
                     adj_cnt_reg <= adj_cnt_reg + 5'h01;
                  end
                  ma_reg <= row_start_reg;
               end
            end else begin
               h_cnt_reg <= h_cnt_reg + 8'h01;
               ma_reg <= ma_reg + 14'h0001;
            end
            // Frame sync pulse
            if (vs_start) begin
               vsync_reg <= 1'b1;
               vs_cnt_reg <= 4'h0;
            end else if (vsync_reg && line_end) begin
               vs_cnt_reg <= vs_cnt_reg + 4'h1;
               if (vs_cnt_reg == `RTC_VSYNC_LINES) begin
                  vsync_reg <= 1'b0;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Light pen capture
   // ----------------------------------------
   // The edge is held pending until the next falling character edge; a new
   // edge in the same cycle as the capture keeps the request alive.
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pen_pend_reg <= 1'b0;
         pen_capture_reg <= `RTC_RST_ADDR;
      end else if (i_ce) begin
         if (i_pen_strobe_pin && !pen_q_reg) begin
            pen_pend_reg <= 1'b1;
         end else if (char_fall) begin
            pen_pend_reg <= 1'b0;
         end
         if (char_fall && pen_pend_reg) begin
            pen_capture_reg <= ma_reg;
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Active-high syncs
   assign o_line_sync_pulse = hsync_reg;
   assign o_frame_sync_pulse = vsync_reg;
   assign o_display_enable = de_reg;
   assign o_cursor = cursor_reg;
   assign o_refresh_address_out = ma_reg[MA_W-1:0];
   assign o_char_row_address_out = raster_reg[RA_W-1:0];

endmodule // rtc_raster_controller

// *** include/rtc_defines.vh ***
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define RTC_IDX_H_TOTAL 5'h00
`define RTC_IDX_H_DISP 5'h01
`define RTC_IDX_H_SYNC_POS 5'h02
`define RTC_IDX_H_SYNC_WID 5'h03
`define RTC_IDX_V_TOTAL 5'h04
`define RTC_IDX_V_ADJUST 5'h05
`define RTC_IDX_V_DISP 5'h06
`define RTC_IDX_V_SYNC_POS 5'h07
`define RTC_IDX_INTERLACE 5'h08
`define RTC_IDX_MAX_SCAN 5'h09
`define RTC_IDX_CUR_FIRST 5'h0a
`define RTC_IDX_CUR_LAST 5'h0b
`define RTC_IDX_START_HI 5'h0c
`define RTC_IDX_START_LO 5'h0d
`define RTC_IDX_CUR_POS_HI 5'h0e
`define RTC_IDX_CUR_POS_LO 5'h0f
`define RTC_IDX_PEN_HI 5'h10
`define RTC_IDX_PEN_LO 5'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTC_MODE_INTERLACE_BIT 0
`define RTC_MODE_VIDEO_BIT 1
`define RTC_CUR_RATE_BIT 5
`define RTC_CUR_BLINK_BIT 6
`define RTC_CUR_LINE_MSB 4

// ----------------------------------------
// Reset values of control registers
// ----------------------------------------
`define RTC_RST_BYTE 8'h00
`define RTC_RST_ADDR 14'h0000
`define RTC_RST_INDEX 5'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define RTC_VSYNC_LINES 4'hf
`define RTC_RESET_MIN_CYCLES 1

`endif

// *** testbench/rtc_raster_checker.sv ***
`timescale 1ns/10ps
module rtc_raster_checker #(
   parameter MA_W = 14,
   parameter RA_W = 5
) (
   input wire i_clk,
   input wire i_arst_n,
   input wire i_ce,
   input wire i_char_clk,
   input wire i_chip_reset_n,
   input wire i_pen_strobe_pin,
   input wire i_bus_enable,
   input wire i_cs_n,
   input wire i_register_select,
   input wire i_read_write_n,
   input wire [7:0] i_host_data_bus,
   input wire [7:0] o_host_data_bus,
   input wire o_host_data_bus_oe,
   input wire o_line_sync_pulse,
   input wire o_frame_sync_pulse,
   input wire o_display_enable,
   input wire o_cursor,
   input wire [MA_W-1:0] o_refresh_address_out,
   input wire [RA_W-1:0] o_char_row_address_out,
   input wire o_test_mode
);
   // ----------------------------------------
   // Cycles since a character clock fall
   // ----------------------------------------
   reg char_prev_reg;
   reg [2:0] since_fall_reg;
   wire hold_now = !i_chip_reset_n && !i_pen_strobe_pin;
   wire quiet = !o_line_sync_pulse && !o_frame_sync_pulse && !o_display_enable && !o_cursor;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         char_prev_reg <= 1'b0;
         since_fall_reg <= 3'h7;
      end else begin
         char_prev_reg <= i_char_clk;
         if (char_prev_reg && !i_char_clk)
            since_fall_reg <= 3'h0;
         else if (since_fall_reg != 3'h7)
            since_fall_reg <= since_fall_reg + 3'h1;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   oe_read_a: assert property (o_host_data_bus_oe == (i_bus_enable && !i_cs_n && i_read_write_n))
      else $error("data bus driven outside a read");
   idle_z_a: assert property (i_cs_n |-> !o_host_data_bus_oe)
      else $error("data bus driven while deselected");
   write_no_oe_a: assert property (!i_read_write_n |-> !o_host_data_bus_oe)
      else $error("data bus driven during a write");
   read_data_a: assert property ($changed(o_host_data_bus) |-> $past(i_bus_enable && !i_cs_n && i_read_write_n))
      else $error("read data moved without a read");
   test_mode_a: assert property (o_test_mode == (!i_chip_reset_n && i_pen_strobe_pin))
      else $error("test mode flag wrong");
   chip_clear_a: assert property (hold_now && $past(hold_now && !i_char_clk, 2) && $past(hold_now && !i_char_clk)
      |-> quiet && o_char_row_address_out == 0 && o_refresh_address_out == 0)
      else $error("outputs not cleared in chip reset");
   ma_char_a: assert property ($changed(o_refresh_address_out) |-> since_fall_reg <= 3'h1)
      else $error("refresh address moved off the character edge");
   ra_char_a: assert property ($changed(o_char_row_address_out) |-> since_fall_reg <= 3'h1)
      else $error("row address moved off the character edge");
   arst_clear_a: assert property (disable iff (1'b0) !i_arst_n |-> quiet && o_refresh_address_out == 0)
      else $error("outputs not cleared in reset");
   cover property (o_host_data_bus_oe);
   cover property (o_test_mode);
   cover property ($rose(o_cursor));
   cover property ($rose(o_display_enable));
endmodule // rtc_raster_checker

// *** testbench/rtc_host_model.sv ***
`timescale 1ns/10ps
module rtc_host_model (
   input wire i_clk,
   input wire [7:0] i_rdata,
   output reg o_e,
   output reg o_cs_n,
   output reg o_rs,
   output reg o_rw_n,
   output reg [7:0] o_data
);
   initial begin
      o_e = 1'b0;
      o_cs_n = 1'b1;
      o_rs = 1'b0;
      o_rw_n = 1'b1;
      o_data = 8'h00;
   end
   // select held over the strobe fall
   task wr(input rs, input [7:0] d);
      begin
         @(negedge i_clk);
         {o_cs_n, o_rs, o_rw_n, o_data, o_e} = {1'b0, rs, 1'b0, d, 1'b1};
         @(negedge i_clk);
         o_e = 1'b0;
         @(negedge i_clk);
         o_cs_n = 1'b1;
         // Released lines toggle so a stale value never looks valid
         o_data = ~d;
      end
   endtask
   // read taken before the strobe falls
   task rd(input rs, output [7:0] d);
      begin
         @(negedge i_clk);
         {o_cs_n, o_rs, o_rw_n, o_e} = {1'b0, rs, 1'b1, 1'b1};
         repeat (2) @(negedge i_clk);
         d = i_rdata;
         o_e = 1'b0;
         @(negedge i_clk);
         o_cs_n = 1'b1;
      end
   endtask
endmodule // rtc_host_model

// *** testbench/rtc_raster_controller_test.sv ***
`timescale 1ns/10ps
module rtc_raster_controller_test;
   localparam MA_W = 14;
   localparam RA_W = 5;
   // Timing table, index 0 in the low byte
   localparam [127:0] TBL = 128'h02000000010001000302000302050407;
   reg i_clk, i_arst_n, i_char_clk, i_chip_reset_n, i_pen_strobe_pin, char_run;
   wire e, cs_n, rs, rw_n, oe, hs, vs, de, cur, tm;
   wire [7:0] wdata, rdata;
   wire [13:0] ma;
   wire [4:0] ra;
   integer miscompares = 0;
   integer total_checks = 0;
   reg [13:0] sa [0:79];
   reg [4:0] sr [0:79];
   reg sc [0:79];
   reg sd [0:79];
   reg sh [0:79];
   rtc_raster_controller i_rtc_raster_controller (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
      .i_char_clk(i_char_clk), .i_chip_reset_n(i_chip_reset_n), .i_pen_strobe_pin(i_pen_strobe_pin),
      .i_bus_enable(e), .i_cs_n(cs_n), .i_register_select(rs), .i_read_write_n(rw_n), .i_host_data_bus(wdata),
      .o_host_data_bus(rdata), .o_host_data_bus_oe(oe), .o_line_sync_pulse(hs), .o_frame_sync_pulse(vs),
      .o_display_enable(de), .o_cursor(cur), .o_refresh_address_out(ma), .o_char_row_address_out(ra),
      .o_test_mode(tm));
   rtc_host_model i_rtc_host_model (.i_clk(i_clk), .i_rdata(rdata), .o_e(e), .o_cs_n(cs_n), .o_rs(rs),
      .o_rw_n(rw_n), .o_data(wdata));
   // ----------------------------------------
   // Clocks and watchdog
   // ----------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      i_char_clk = 1'b0;
      forever begin
         repeat (2) @(negedge i_clk);
         if (char_run) i_char_clk = ~i_char_clk;
      end
   end
   initial begin
      #3000000;
      miscompares = miscompares + 1;
      complete_run;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk_val(input [13:0] got, input [13:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task chk_bit(input got, input exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
         end
      end
   endtask
   task reg_wr(input [4:0] idx, input [7:0] d);
      begin
         i_rtc_host_model.wr(1'b0, {3'h0, idx});
         i_rtc_host_model.wr(1'b1, d);
      end
   endtask
   task reg_rd(input [4:0] idx, output [7:0] d);
      begin
         i_rtc_host_model.wr(1'b0, {3'h0, idx});
         i_rtc_host_model.rd(1'b1, d);
      end
   endtask
   task samp(input integer n);
      integer j;
      for (j = 0; j < n; j = j + 1) begin
         @(posedge i_char_clk);
         {sa[j], sr[j], sc[j], sd[j], sh[j]} = {ma, ra, cur, de, hs};
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task test_regs;
      reg [7:0] d;
      begin
         reg_wr(5'h0e, 8'hff);
         reg_wr(5'h0f, 8'ha5);
         reg_rd(5'h0e, d);
         chk_val({6'h00, d}, 14'h003f);
         reg_rd(5'h0f, d);
         chk_val({6'h00, d}, 14'h00a5);
         reg_wr(5'h0c, 8'h15);
         reg_rd(5'h0c, d);
         chk_val({6'h00, d}, 14'h0000);
         reg_wr(5'h11, 8'h5a);
         reg_rd(5'h11, d);
         chk_val({6'h00, d}, 14'h0000);
         i_rtc_host_model.rd(1'b0, d);
         chk_val({6'h00, d}, 14'h0000);
      end
   endtask
   task test_timing;
      integer j, k;
      begin
         for (j = 0; j < 16; j = j + 1) reg_wr(j[4:0], TBL[j*8 +: 8]);
         @(negedge i_clk) i_chip_reset_n = 1'b0;
         repeat (8) @(negedge i_clk);
         chk_val({5'h00, vs, hs, de, cur, ra}, 14'h0000);
         chk_val(ma, 14'h0000);
         i_chip_reset_n = 1'b1;
         samp(24);
         k = 0;
         while (k < 3 && sa[k+1] === 14'h0000) k = k + 1;
         for (j = 0; j < 8; j = j + 1) begin
            chk_val(sa[k+j], 14'(j));
            chk_val(sa[k+8+j], 14'(j));
            chk_val({9'h000, sr[k+j]}, 14'h0000);
            chk_val({9'h000, sr[k+8+j]}, 14'h0001);
         end
         chk_val(sa[k+16], 14'h0004);
         chk_val({9'h000, sr[k+16]}, 14'h0000);
         chk_bit(sd[k+1], 1'b1);
         chk_bit(sd[k+5], 1'b0);
         chk_bit(sh[k+5], 1'b0);
         chk_bit(sh[k+6], 1'b1);
         chk_bit(sh[k+7], 1'b1);
         chk_bit(sh[k+8], 1'b0);
         chk_bit(sc[k+2], 1'b0);
         chk_bit(sc[k+3], 1'b1);
         chk_bit(sc[k+11], 1'b1);
      end
   endtask
   task test_start;
      integer j;
      reg found;
      begin
         reg_wr(5'h0d, 8'h23);
         reg_wr(5'h0c, 8'h01);
         chk_bit(vs, 1'b0);
         samp(80);
         found = 1'b0;
         for (j = 0; j < 79; j = j + 1)
            if (sa[j] === 14'h0123 && sa[j+1] === 14'h0124) found = 1'b1;
         chk_bit(found, 1'b1);
         chk_bit(vs, 1'b1);
      end
   endtask
   task test_mode;
      begin
         @(negedge i_clk) i_pen_strobe_pin = 1'b1;
         @(negedge i_clk) i_chip_reset_n = 1'b0;
         @(negedge i_clk);
         chk_bit(tm, 1'b1);
         samp(4);
         chk_bit(sa[0] !== sa[3], 1'b1);
         i_chip_reset_n = 1'b1;
         i_pen_strobe_pin = 1'b0;
         samp(2);
         chk_bit(tm, 1'b0);
         chk_bit(sa[0] !== sa[1], 1'b1);
      end
   endtask
   task test_pen;
      reg [13:0] a;
      reg [7:0] d;
      begin
         // Freezing the character clock pins the address the strobe must catch
         @(posedge i_char_clk) char_run = 1'b0;
         repeat (4) @(negedge i_clk);
         a = ma;
         i_pen_strobe_pin = 1'b1;
         repeat (3) @(negedge i_clk);
         char_run = 1'b1;
         repeat (8) @(negedge i_clk);
         i_pen_strobe_pin = 1'b0;
         reg_rd(5'h10, d);
         chk_val({8'h00, d[5:0]}, {8'h00, a[13:8]});
         chk_val({6'h00, d[7:6], 6'h00}, 14'h0000);
         reg_rd(5'h11, d);
         chk_val({6'h00, d}, {6'h00, a[7:0]});
      end
   endtask
   initial begin
      {i_arst_n, i_chip_reset_n, i_pen_strobe_pin, char_run} = 4'b0101;
      repeat (8) @(negedge i_clk);
      i_arst_n = 1'b1;
      test_regs;
      test_timing;
      test_start;
      test_mode;
      test_pen;
      complete_run;
   end
endmodule // rtc_raster_controller_test
bind rtc_raster_controller rtc_raster_checker #(.MA_W(MA_W), .RA_W(RA_W)) i_rtc_raster_checker (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_char_clk(i_char_clk), .i_chip_reset_n(i_chip_reset_n),
   .i_pen_strobe_pin(i_pen_strobe_pin), .i_bus_enable(i_bus_enable), .i_cs_n(i_cs_n),
   .i_register_select(i_register_select), .i_read_write_n(i_read_write_n), .i_host_data_bus(i_host_data_bus),
   .o_host_data_bus(o_host_data_bus), .o_host_data_bus_oe(o_host_data_bus_oe),
   .o_line_sync_pulse(o_line_sync_pulse), .o_frame_sync_pulse(o_frame_sync_pulse),
   .o_display_enable(o_display_enable), .o_cursor(o_cursor), .o_refresh_address_out(o_refresh_address_out),
   .o_char_row_address_out(o_char_row_address_out), .o_test_mode(o_test_mode));
